// ### uart_pkg.sv
/*
 * Constants shared by the asynchronous serial port: divisor width, frame
 * field limits, parity and DMA priority encodings, reset values.
 * Assumes nothing of its surroundings; imported whole by the port, checker, peer and bench files.
 */
package uart_pkg;

   // *************************************************************
   // Frame format
   // *************************************************************
   localparam int DIV_W = 16;                     // 16 * 65535 = 1,048,560 clocks in the longest bit
   localparam int OVS = 16;                       // Samples per bit
   localparam logic [3:0] OVS_MID = 4'h7;         // Sample tick for bit middle
   localparam logic [3:0] OVS_LAST = 4'hf;
   localparam logic [1:0] LEN_5 = 2'h0;           // Length code 0..3 = 5..8 bits
   localparam logic [2:0] LEN_BASE = 3'h4;        // Last data index = base + code, plus one in nine-bit mode
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam logic [DIV_W-1:0] DIV_RST = 16'h0001;
   localparam logic [1:0] DMA_PRIO_RST = 2'h0;    // Lowest arbitration class
   localparam int BUF_DEPTH = 2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
   } ser_state_t;

endpackage : uart_pkg

// ### uart_buf2.sv
/*
 * Two-entry buffer with valid/ready on both sides; read data come from
 * registers. Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
module uart_buf2 #(
   parameter int WIDTH = 9
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   logic [WIDTH-1:0] head_r, head_nxt, tail_r, tail_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop, ready_nxt, valid_nxt;

   // *************************************************************
   // Head holds the oldest word, tail the second
   // *************************************************************
   always_comb begin
      push = wr_valid_in && (cnt_r != 2'h2);
      pop = rd_ready_in && (cnt_r != 2'h0);
      head_nxt = head_r;
      tail_nxt = tail_r;
      cnt_nxt = cnt_r + 2'(push) - 2'(pop);
      ready_nxt = (cnt_nxt != 2'h2);
      valid_nxt = (cnt_nxt != 2'h0);
      if (pop) begin
         head_nxt = (cnt_r == 2'h2) ? tail_r : wr_data_in;
      end
      if (push) begin
         if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
            head_nxt = wr_data_in;
         end else begin
            tail_nxt = wr_data_in;
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         head_r <= '0;
         tail_r <= '0;
         cnt_r <= 2'h0;
         wr_ready_out <= 1'b1;
         rd_valid_out <= 1'b0;
      end else begin
         head_r <= head_nxt;
         tail_r <= tail_nxt;
         cnt_r <= cnt_nxt;
         // Flags registered so the handshake outputs leave a flop, same timing as count
         wr_ready_out <= ready_nxt;
         rd_valid_out <= valid_nxt;
      end
   end

   assign rd_data_out = head_r;

endmodule : uart_buf2

// ### async_serial_port.sv
/*
 * Full-duplex asynchronous serial port with two-stage buffers on both paths,
 * programmed-I/O and DMA request sides, and a timing-capture output for an
 * external timer doing autobaud. Assumes a single clock; the receive line
 * comes from a pin and is synchronised here.
 */
`timescale 1ns/1ns
module async_serial_port
   import uart_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [DIV_W-1:0] divisor_in,
   input wire logic [1:0] char_len_in,
   input wire logic two_stop_in,
   input wire logic [1:0] parity_in,
   input wire logic nine_bit_in,
   input wire logic addr_filter_in,
   input wire logic [7:0] node_addr_in,
   input wire logic dma_mode_in,
   input wire logic tx_irq_en_in,
   input wire logic rx_irq_en_in,
   input wire logic [8:0] tx_data_in,
   input wire logic tx_valid_in,
   input wire logic rx_ready_in,
   input wire logic err_clr_in,
   input wire logic rxd_in,
   output logic txd_out,
   output logic tx_ready_out,
   output logic [8:0] rx_data_out,
   output logic rx_valid_out,
   output logic parity_err_out,
   output logic frame_err_out,
   output logic overrun_out,
   output logic tx_irq_out,
   output logic rx_irq_out,
   output logic tx_dma_req_out,
   output logic rx_dma_req_out,
   output logic [1:0] dma_prio_out,
   output logic rx_edge_out
);

   // *************************************************************
   // Input synchroniser and baud tick
   // *************************************************************
   logic rx_s1_r, rx_s2_r, rx_s3_r;
   logic [DIV_W-1:0] div_cnt_r, div_cnt_nxt;
   logic tick;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
         rx_s3_r <= 1'b1;
      end else begin
         rx_s1_r <= rxd_in;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
      end
   end

   // One tick per divisor clocks, sixteen ticks per bit; divisor 0 acts as 1
   always_comb begin
      tick = (div_cnt_r <= 16'h0001);
      div_cnt_nxt = tick ? divisor_in : div_cnt_r - 16'h0001;
   end

   // *************************************************************
   // Buffers: two stages per path
   // *************************************************************
   logic [8:0] txb_data, rxw_data_r, rxw_data_nxt;
   logic txb_valid, txb_take, rxb_ready, rxw_valid_r, rxw_valid_nxt;
   logic rxb_out_valid;
   logic [8:0] rxb_out_data;

   uart_buf2 #(.WIDTH(9)) u_txbuf (
      .clk_in(clk_in), .nrst_in(nrst_in),
      .wr_data_in(tx_data_in), .wr_valid_in(tx_valid_in), .wr_ready_out(tx_ready_out),
      .rd_data_out(txb_data), .rd_valid_out(txb_valid), .rd_ready_in(txb_take)
   );

   uart_buf2 #(.WIDTH(9)) u_rxbuf (
      .clk_in(clk_in), .nrst_in(nrst_in),
      .wr_data_in(rxw_data_r), .wr_valid_in(rxw_valid_r), .wr_ready_out(rxb_ready),
      .rd_data_out(rxb_out_data), .rd_valid_out(rxb_out_valid), .rd_ready_in(rx_ready_in)
   );

   // *************************************************************
   // Transmitter
   // *************************************************************
   ser_state_t tx_st_r, tx_st_nxt;
   logic [3:0] tx_ph_r, tx_ph_nxt;
   logic [3:0] tx_bit_r, tx_bit_nxt;
   logic [8:0] tx_sh_r, tx_sh_nxt;
   logic tx_par_r, tx_par_nxt, txd_nxt, tx_stop2_r, tx_stop2_nxt;
   logic [3:0] last_idx;

   assign last_idx = {1'b0, LEN_BASE} + {2'b00, char_len_in} + {3'b000, nine_bit_in};

   always_comb begin
      tx_st_nxt = tx_st_r;
      tx_ph_nxt = tx_ph_r;
      tx_bit_nxt = tx_bit_r;
      tx_sh_nxt = tx_sh_r;
      tx_par_nxt = tx_par_r;
      tx_stop2_nxt = tx_stop2_r;
      txd_nxt = txd_out;
      txb_take = 1'b0;
      if (tick) begin
         tx_ph_nxt = tx_ph_r + 4'h1;
      end
      unique case (tx_st_r)
         ST_IDLE: begin
            txd_nxt = 1'b1;
            tx_ph_nxt = 4'h0;
            if (txb_valid) begin
               txb_take = 1'b1;
               tx_sh_nxt = txb_data;
               tx_par_nxt = (parity_in == PAR_ODD);
               tx_st_nxt = ST_START;
               txd_nxt = 1'b0;
            end
         end
         ST_START: if (tick && tx_ph_r == OVS_LAST) begin
            tx_st_nxt = ST_DATA;
            tx_bit_nxt = 4'h0;
            txd_nxt = tx_sh_r[0];
         end
         ST_DATA: if (tick && tx_ph_r == OVS_LAST) begin
            tx_par_nxt = tx_par_r ^ tx_sh_r[0];
            tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
            tx_bit_nxt = tx_bit_r + 4'h1;
            if (tx_bit_r == last_idx) begin
               tx_stop2_nxt = two_stop_in;
               if (parity_in != PAR_NONE) begin
                  tx_st_nxt = ST_PAR;
                  txd_nxt = tx_par_r ^ tx_sh_r[0];
               end else begin
                  tx_st_nxt = ST_STOP;
                  txd_nxt = 1'b1;
               end
            end else begin
               txd_nxt = tx_sh_r[1];
            end
         end
         ST_PAR: if (tick && tx_ph_r == OVS_LAST) begin
            tx_st_nxt = ST_STOP;
            txd_nxt = 1'b1;
         end
         ST_STOP: if (tick && tx_ph_r == OVS_LAST) begin
            if (tx_stop2_r) begin
               tx_stop2_nxt = 1'b0;
            end else begin
               tx_st_nxt = ST_IDLE;
            end
         end
         default: tx_st_nxt = ST_IDLE;
      endcase
   end

   // *************************************************************
   // Receiver: find start, sample each bit at tick 7 of 16
   // *************************************************************
   ser_state_t rx_st_r, rx_st_nxt;
   logic [3:0] rx_ph_r, rx_ph_nxt, rx_bit_r, rx_bit_nxt;
   logic [8:0] rx_sh_r, rx_sh_nxt;
   logic rx_par_r, rx_par_nxt, rx_stop2_r, rx_stop2_nxt, mid;
   logic perr_r, perr_nxt, ferr_r, ferr_nxt, ovr_r, ovr_nxt;
   logic perr_set, ferr_set, ovr_set, take_frame;

   always_comb begin
      mid = tick && (rx_ph_r == OVS_MID);
      rx_st_nxt = rx_st_r;
      rx_ph_nxt = tick ? rx_ph_r + 4'h1 : rx_ph_r;
      rx_bit_nxt = rx_bit_r;
      rx_sh_nxt = rx_sh_r;
      rx_par_nxt = rx_par_r;
      rx_stop2_nxt = rx_stop2_r;
      rxw_data_nxt = rxw_data_r;
      rxw_valid_nxt = rxw_valid_r && !rxb_ready;
      perr_set = 1'b0;
      ferr_set = 1'b0;
      ovr_set = 1'b0;
      take_frame = 1'b0;
      unique case (rx_st_r)
         ST_IDLE: begin
            rx_ph_nxt = 4'h0;
            if (!rx_s3_r) begin
               rx_st_nxt = ST_START;
            end
         end
         ST_START: if (mid) begin
            // A start bit gone high by mid-bit was a glitch
            rx_st_nxt = rx_s3_r ? ST_IDLE : ST_DATA;
            rx_bit_nxt = 4'h0;
            rx_sh_nxt = 9'h000;
            rx_par_nxt = (parity_in == PAR_ODD);
         end
         ST_DATA: if (mid) begin
            rx_sh_nxt[rx_bit_r] = rx_s3_r;
            rx_par_nxt = rx_par_r ^ rx_s3_r;
            rx_bit_nxt = rx_bit_r + 4'h1;
            if (rx_bit_r == last_idx) begin
               rx_stop2_nxt = two_stop_in;
               rx_st_nxt = (parity_in != PAR_NONE) ? ST_PAR : ST_STOP;
            end
         end
         ST_PAR: if (mid) begin
            perr_set = (rx_par_r != rx_s3_r);
            rx_st_nxt = ST_STOP;
         end
         ST_STOP: if (mid) begin
            ferr_set = !rx_s3_r;
            if (rx_stop2_r && rx_s3_r) begin
               rx_stop2_nxt = 1'b0;
            end else begin
               rx_st_nxt = ST_IDLE;
               // Address filter: data frames pass only after our address matched
               take_frame = !addr_filter_in || !nine_bit_in || rx_sh_r[last_idx] || addr_hit_r;
            end
         end
         default: rx_st_nxt = ST_IDLE;
      endcase
      if (take_frame) begin
         if (rxw_valid_r && !rxb_ready) begin
            ovr_set = 1'b1;
         end else begin
            rxw_valid_nxt = 1'b1;
            rxw_data_nxt = nine_bit_in ? {rx_sh_r[last_idx], rx_sh_r[7:0]} : rx_sh_r;
         end
      end
      // Set wins over clear so no event is lost
      perr_nxt = perr_set || (perr_r && !err_clr_in);
      ferr_nxt = ferr_set || (ferr_r && !err_clr_in);
      ovr_nxt = ovr_set || (ovr_r && !err_clr_in);
   end

   // *************************************************************
   // Multidrop address match, kept until the next address frame
   // *************************************************************
   logic addr_hit_r, addr_hit_nxt, rx_is_addr;
   always_comb begin
      rx_is_addr = nine_bit_in && rxw_data_nxt[8] && rxw_valid_nxt && !rxw_valid_r;
      addr_hit_nxt = rx_is_addr ? (rxw_data_nxt[7:0] == node_addr_in) : addr_hit_r;
   end

   // *************************************************************
   // Registers of both paths
   // *************************************************************
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div_cnt_r <= DIV_RST;
         tx_st_r <= ST_IDLE;
         tx_ph_r <= 4'h0;
         tx_bit_r <= 4'h0;
         tx_sh_r <= 9'h000;
         tx_par_r <= 1'b0;
         tx_stop2_r <= 1'b0;
         txd_out <= 1'b1;
         rx_st_r <= ST_IDLE;
         rx_ph_r <= 4'h0;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 9'h000;
         rx_par_r <= 1'b0;
         rx_stop2_r <= 1'b0;
         rxw_data_r <= 9'h000;
         rxw_valid_r <= 1'b0;
         perr_r <= 1'b0;
         ferr_r <= 1'b0;
         ovr_r <= 1'b0;
         addr_hit_r <= 1'b0;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         tx_st_r <= tx_st_nxt;
         tx_ph_r <= tx_ph_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_par_r <= tx_par_nxt;
         tx_stop2_r <= tx_stop2_nxt;
         txd_out <= txd_nxt;
         rx_st_r <= rx_st_nxt;
         rx_ph_r <= rx_ph_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_par_r <= rx_par_nxt;
         rx_stop2_r <= rx_stop2_nxt;
         rxw_data_r <= rxw_data_nxt;
         rxw_valid_r <= rxw_valid_nxt;
         perr_r <= perr_nxt;
         ferr_r <= ferr_nxt;
         ovr_r <= ovr_nxt;
         addr_hit_r <= addr_hit_nxt;
      end
   end

   // *************************************************************
   // Requests, status and autobaud edge, all registered
   // *************************************************************
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rx_data_out <= 9'h000;
         rx_valid_out <= 1'b0;
         tx_irq_out <= 1'b0;
         rx_irq_out <= 1'b0;
         tx_dma_req_out <= 1'b0;
         rx_dma_req_out <= 1'b0;
         dma_prio_out <= DMA_PRIO_RST;
         rx_edge_out <= 1'b0;
         parity_err_out <= 1'b0;
         frame_err_out <= 1'b0;
         overrun_out <= 1'b0;
      end else begin
         rx_data_out <= rxb_out_data;
         rx_valid_out <= rxb_out_valid;
         tx_irq_out <= tx_irq_en_in && !dma_mode_in && tx_ready_out;
         rx_irq_out <= rx_irq_en_in && !dma_mode_in && rxb_out_valid;
         tx_dma_req_out <= dma_mode_in && tx_ready_out;
         rx_dma_req_out <= dma_mode_in && rxb_out_valid;
         dma_prio_out <= DMA_PRIO_RST;
         rx_edge_out <= rx_s2_r ^ rx_s3_r;
         parity_err_out <= perr_nxt;
         frame_err_out <= ferr_nxt;
         overrun_out <= ovr_nxt;
      end
   end

endmodule : async_serial_port

// ### async_serial_port_assertions.sv
/* Checker on the top ports of the asynchronous serial port.
   Assumes one clock and an active-low asynchronous reset; bound from the bench. */
`timescale 1ns/1ns
module async_serial_port_assertions
   import uart_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic dma_mode_in,
   input wire logic tx_irq_en_in,
   input wire logic rx_irq_en_in,
   input wire logic rx_ready_in,
   input wire logic err_clr_in,
   input wire logic rxd_in,
   input wire logic txd_out,
   input wire logic [8:0] rx_data_out,
   input wire logic rx_valid_out,
   input wire logic parity_err_out,
   input wire logic frame_err_out,
   input wire logic tx_irq_out,
   input wire logic rx_irq_out,
   input wire logic tx_dma_req_out,
   input wire logic rx_dma_req_out,
   input wire logic [1:0] dma_prio_out,
   input wire logic rx_edge_out
);
   // ************************************************************
   // Port relations
   // ************************************************************
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   property p_prio;
      dma_prio_out == DMA_PRIO_RST;
   endproperty
   a_prio: assert property (p_prio) else $error("dma priority class changed");
   // Any low run on the line is checked to last at least 8 clocks, half the 16 of the shortest bit
   property p_low_run;
      $fell(txd_out) |-> !txd_out [*8];
   endproperty
   a_low_run: assert property (p_low_run) else $error("txd low pulse too short");
   property p_excl;
      !(tx_irq_out && tx_dma_req_out) && !(rx_irq_out && rx_dma_req_out);
   endproperty
   a_excl: assert property (p_excl) else $error("irq and dma request together");
   // Mask takes one edge to reach the registered request; the check allows two
   property p_tx_mask;
      tx_irq_out |-> $past(tx_irq_en_in) || $past(tx_irq_en_in, 2);
   endproperty
   a_tx_mask: assert property (p_tx_mask) else $error("tx irq while masked");
   property p_rx_mask;
      rx_irq_out |-> $past(rx_irq_en_in) || $past(rx_irq_en_in, 2);
   endproperty
   a_rx_mask: assert property (p_rx_mask) else $error("rx irq while masked");
   // Valid lags a pop by one cycle, so the cycle after a pop is exempt
   property p_rx_hold;
      rx_valid_out && !rx_ready_in && !$past(rx_ready_in) |=>
         rx_valid_out && $stable(rx_data_out);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx word lost unpopped");
   property p_par_sticky;
      parity_err_out && !err_clr_in |=> parity_err_out;
   endproperty
   a_par_sticky: assert property (p_par_sticky) else $error("parity flag dropped");
   property p_frm_sticky;
      frame_err_out && !err_clr_in |=> frame_err_out;
   endproperty
   a_frm_sticky: assert property (p_frm_sticky) else $error("frame flag dropped");
   property p_edge;
      $fell(rxd_in) |-> ##[1:4] rx_edge_out;
   endproperty
   a_edge: assert property (p_edge) else $error("rx edge not offered");
endmodule : async_serial_port_assertions

// ### serial_peer.sv
/* Remote serial node: sends frames on the port's receive line and decodes
   frames from its transmit line. Assumes bench sets bit_clks to match divisor. */
`timescale 1ns/1ns
module serial_peer
   import uart_pkg::*;
(
   input wire logic clk_in,
   input wire logic txd_in,
   output logic rxd_out
);
   int bit_clks = 16;
   int cyc = 0;
   int t_start = 0;
   initial rxd_out = 1'b1;
   always @(posedge clk_in) cyc <= cyc + 1;

   // Start low, data LSB first, optional parity, stops high; errors on demand
   task automatic send(input logic [8:0] d, input int n, input logic [1:0] par,
                       input int stops, input bit bad_par, input bit bad_stop);
      logic p;
      p = ^(d & ((9'h1 << n) - 9'h1)) ^ (par == PAR_ODD) ^ bad_par;
      @(posedge clk_in);
      rxd_out <= 1'b0;
      repeat (bit_clks) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         rxd_out <= d[i];
         repeat (bit_clks) @(posedge clk_in);
      end
      if (par != PAR_NONE) begin
         rxd_out <= p;
         repeat (bit_clks) @(posedge clk_in);
      end
      for (int i = 0; i < stops; i++) begin
         rxd_out <= !bad_stop;
         repeat (bit_clks) @(posedge clk_in);
      end
      rxd_out <= 1'b1;
   endtask : send

   // Samples mid-bit; polling after the edge delays detection equally each frame
   task automatic recv(output logic [8:0] d, output logic p, output logic ok,
                       input int n, input bit has_par, input int stops);
      int t;
      t = 0;
      d = '0;
      p = 1'b0;
      ok = 1'b1;
      while (txd_in !== 1'b0 && t < 4000) begin
         @(posedge clk_in);
         t++;
      end
      t_start = cyc;
      repeat (bit_clks / 2) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         repeat (bit_clks) @(posedge clk_in);
         d[i] = txd_in;
      end
      if (has_par) begin
         repeat (bit_clks) @(posedge clk_in);
         p = txd_in;
      end
      for (int i = 0; i < stops; i++) begin
         repeat (bit_clks) @(posedge clk_in);
         ok = ok & (txd_in === 1'b1);
      end
   endtask : recv
endmodule : serial_peer

// ### async_serial_port_bench.sv
/* Self-checking bench for the asynchronous serial port with a remote peer.
   Assumes 25 MHz clock; every input changes by non-blocking write at posedge. */
`timescale 1ns/1ns
module async_serial_port_bench;
   import uart_pkg::*;
   logic clk_in = 1'b0, nrst_in = 1'b0;
   logic [DIV_W-1:0] divisor_in = 16'h0001;
   logic [1:0] char_len_in = 2'h3, parity_in = 2'h0;
   logic two_stop_in = 1'b0, nine_bit_in = 1'b0, addr_filter_in = 1'b0;
   logic [7:0] node_addr_in = 8'h00;
   logic dma_mode_in = 1'b0, tx_irq_en_in = 1'b0, rx_irq_en_in = 1'b0;
   logic [8:0] tx_data_in = 9'h000;
   logic tx_valid_in = 1'b0, rx_ready_in = 1'b0, err_clr_in = 1'b0;
   logic rxd_in, txd_out, tx_ready_out, rx_valid_out, parity_err_out, frame_err_out;
   logic overrun_out, tx_irq_out, rx_irq_out, tx_dma_req_out, rx_dma_req_out, rx_edge_out;
   logic [8:0] rx_data_out;
   logic [1:0] dma_prio_out;
   int failures = 0, tests_run = 0, cyc = 0;

   always #20 clk_in = ~clk_in;

   async_serial_port uut (.clk_in, .nrst_in, .divisor_in, .char_len_in, .two_stop_in,
      .parity_in, .nine_bit_in, .addr_filter_in, .node_addr_in, .dma_mode_in,
      .tx_irq_en_in, .rx_irq_en_in, .tx_data_in, .tx_valid_in, .rx_ready_in, .err_clr_in,
      .rxd_in, .txd_out, .tx_ready_out, .rx_data_out, .rx_valid_out, .parity_err_out,
      .frame_err_out, .overrun_out, .tx_irq_out, .rx_irq_out, .tx_dma_req_out,
      .rx_dma_req_out, .dma_prio_out, .rx_edge_out);
   serial_peer peer (.clk_in, .txd_in(txd_out), .rxd_out(rxd_in));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_n(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_n
   task automatic end_sim;
      $display("Compared %0d, mismatched %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic cfg(input logic [1:0] len, input logic [1:0] par, input logic two,
                      input logic [15:0] dv);
      @(posedge clk_in);
      char_len_in <= len;
      parity_in <= par;
      two_stop_in <= two;
      divisor_in <= dv;
      peer.bit_clks = 16 * int'(dv);
   endtask : cfg
   // Valid stays up between words; ready is judged at the negedge before the taking edge
   task automatic wr(input logic [8:0] d);
      int t;
      t = 0;
      tx_data_in <= d;
      tx_valid_in <= 1'b1;
      do begin
         @(negedge clk_in);
         t++;
      end while (tx_ready_out !== 1'b1 && t < 2000);
      @(posedge clk_in);
   endtask : wr
   // Pop one word, then allow the valid lag to pass
   task automatic pop(input logic [8:0] exp);
      int t;
      t = 0;
      do begin
         @(negedge clk_in);
         t++;
      end while (rx_valid_out !== 1'b1 && t < 3000);
      chk({rx_valid_out, rx_data_out}, {1'b1, exp});
      @(posedge clk_in);
      rx_ready_in <= 1'b1;
      @(posedge clk_in);
      rx_ready_in <= 1'b0;
      @(posedge clk_in);
   endtask : pop
   task automatic flush_clr(input logic [8:0] exp);
      pop(exp);
      err_clr_in <= 1'b1;
      @(posedge clk_in);
      err_clr_in <= 1'b0;
      @(negedge clk_in);
      chk({parity_err_out, frame_err_out, overrun_out, rx_valid_out}, 4'h0);
   endtask : flush_clr

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_tx_fmt;
      logic [8:0] got, e;
      logic p, ok;
      logic [1:0] pc;
      @(negedge clk_in);
      chk({txd_out, tx_ready_out, rx_valid_out, overrun_out, dma_prio_out}, 6'h30);
      for (int i = 0; i < 4; i++) begin
         pc = 2'(i % 3);
         cfg(i[1:0], pc, i[0], 16'h0001);
         e = (9'h0a5 ^ 9'(i)) & ((9'h1 << (5 + i)) - 9'h1);
         wr(9'h0a5 ^ 9'(i));
         tx_valid_in <= 1'b0;
         peer.recv(got, p, ok, 5 + i, pc != PAR_NONE, 1 + i % 2);
         chk({ok, got}, {1'b1, e});
         if (pc != PAR_NONE) chk(p, ^e ^ (pc == PAR_ODD));
      end
      $display("test tx formats done");
   endtask : t_tx_fmt
   // Full buffer refuses; frames follow with no gap while a word comes in
   task automatic t_b2b;
      logic [8:0] got;
      logic p, ok;
      int t0;
      cfg(2'h3, PAR_ODD, 1'b1, 16'h0003);
      fork
         begin
            wr(9'h011);
            wr(9'h022);
            wr(9'h033);
            tx_valid_in <= 1'b0;
            repeat (3) @(negedge clk_in);
            chk(tx_ready_out, 1'b0);
         end
         for (int i = 1; i < 4; i++) begin
            peer.recv(got, p, ok, 8, 1'b1, 2);
            chk({ok, p, got}, {1'b1, ~^(9'h011 * i), 9'(9'h011 * i)});
            if (i > 1) chk_n(peer.t_start - t0, 12 * 48);
            t0 = peer.t_start;
         end
         begin
            peer.send(9'h03c, 8, PAR_ODD, 2, 1'b0, 1'b0);
            pop(9'h03c);
         end
      join
      $display("test back to back done");
   endtask : t_b2b
   // Receiver stalls until a word is lost, then drains in order
   task automatic t_rx;
      cfg(2'h3, PAR_EVEN, 1'b0, 16'h0001);
      for (int i = 0; i < 4; i++) peer.send(9'h0c0 + 9'(i), 8, PAR_EVEN, 1, 1'b0, 1'b0);
      repeat (20) @(posedge clk_in);
      @(negedge clk_in);
      chk({parity_err_out, frame_err_out, overrun_out}, 3'h1);
      for (int i = 0; i < 3; i++) pop(9'h0c0 + 9'(i));
      for (int i = 0; i < 2; i++) begin
         peer.send(9'h05a, 8, PAR_EVEN, 1, i == 0, i == 1);
         repeat (20) @(posedge clk_in);
         @(negedge clk_in);
         chk({parity_err_out, frame_err_out}, (i == 0) ? 2'h2 : 2'h1);
         flush_clr(9'h05a);
      end
      $display("test receive done");
   endtask : t_rx
   task automatic t_req;
      peer.send(9'h077, 8, PAR_EVEN, 1, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         dma_mode_in <= i[1];
         tx_irq_en_in <= i[0];
         rx_irq_en_in <= i[0];
         repeat (3) @(negedge clk_in);
         chk({tx_irq_out, rx_irq_out, tx_dma_req_out, rx_dma_req_out},
             {{2{i[0] & !i[1]}}, {2{i[1]}}});
      end
      flush_clr(9'h077);
      $display("test requests done");
   endtask : t_req
   // Address frames always kept; data after a foreign address is dropped
   task automatic t_addr;
      logic [8:0] got;
      logic p, ok;
      cfg(2'h3, PAR_NONE, 1'b0, 16'h0001);
      nine_bit_in <= 1'b1;
      addr_filter_in <= 1'b1;
      node_addr_in <= 8'h35;
      peer.send(9'h135, 9, PAR_NONE, 1, 1'b0, 1'b0);
      peer.send(9'h0aa, 9, PAR_NONE, 1, 1'b0, 1'b0);
      peer.send(9'h122, 9, PAR_NONE, 1, 1'b0, 1'b0);
      peer.send(9'h055, 9, PAR_NONE, 1, 1'b0, 1'b0);
      pop(9'h135);
      pop(9'h0aa);
      pop(9'h122);
      @(negedge clk_in);
      chk(rx_valid_out, 1'b0);
      // Ninth bit leaves after the eight data bits as the address mark
      @(posedge clk_in);
      wr(9'h1c3);
      tx_valid_in <= 1'b0;
      peer.recv(got, p, ok, 9, 1'b0, 1);
      chk({ok, got}, {1'b1, 9'h1c3});
      $display("test address filter done");
   endtask : t_addr

   // Cycle ceiling cuts a hang short
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         end_sim();
      end
   end

   initial begin
      repeat (4) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_tx_fmt();
      t_b2b();
      t_rx();
      t_req();
      t_addr();
      end_sim();
   end
endmodule : async_serial_port_bench

bind async_serial_port async_serial_port_assertions chk_i (.clk_in, .nrst_in, .dma_mode_in,
   .tx_irq_en_in, .rx_irq_en_in, .rx_ready_in, .err_clr_in, .rxd_in, .txd_out, .rx_data_out,
   .rx_valid_out, .parity_err_out, .frame_err_out, .tx_irq_out, .rx_irq_out, .tx_dma_req_out,
   .rx_dma_req_out, .dma_prio_out, .rx_edge_out);
